// ---- rtl/wec_top.sv ----
// Purpose: Platform wake and power-state controller on standby power
// Assumes: Wake pins are active-high levels from outside the clock domain
// Notes: Setup options arrive as plain levels from firmware storage
// Function
// - Restore prior on/off state after AC loss
// - Support S3 with main power removed
// - S3 indicator amber if dual, else off
// - Enabled wake returns system to working state
// - LAN wake frame request powers system up
// - USB activity wakes from S3, S4, S5
// - USB wake from S4/S5 needs enable option
// - PCIe wake line wakes from S3-S5
// - RTC alarm wakes system from S5
// - Infrared activity wakes from S3, S4, S5
// - Wireless link activity never wakes system
// - RTC/LAN/PCIe wake keeps display asleep from S3
// - USB/IR S4/S5 wake needs deep standby off
// - LAN S5 wake after G3 needs deep off
// - No USB/IR wake right after AC return
// - Only one CEC path active at once
// - External adaptor disables onboard CEC
// - Shutdown S0 to S5 sends TV standby
// - Sleep S0 to S3 sends TV standby
// - Power-on S5 to S0 commands TV on
// - Short switch press wakes to working state
`timescale 1ns/100ps
module wec_top
   import wec_pkg::*;
#(
   parameter int PRESS_LIMIT = PRESS_LIMIT_CYC,
   parameter int AC_QUIET = AC_QUIET_CYC
)
(
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire wec_cfg_t i_cfg,
   input wire logic [NSRC-1:0] i_wake_pin,
   input wire logic i_sleep_s3_req,
   input wire logic i_sleep_s4_req,
   input wire logic i_shutdown_req,
   input wire logic i_ext_cec_present,
   output wec_state_t o_state,
   output logic o_main_pwr_en,
   output logic o_ctx_keep,
   output wec_led_t o_led,
   output logic o_display_hold,
   output logic [NSRC-1:0] o_wake_cause,
   output logic o_cec_onboard_act,
   output logic o_cec_ext_act,
   output wec_cec_t o_cec_cmd
);
   // Synchronised wake pins
   logic [NSRC-1:0] pin_s;
   // Previous synchronised values for edge detection
   logic [NSRC-1:0] pin_prev_q;
   // Rising edges of the wake pins
   logic [NSRC-1:0] pin_rise;
   // Per-source wake qualification
   logic [NSRC-1:0] src_ok;
   // Qualified wake requests
   logic [NSRC-1:0] wake_hit;
   // Any qualified wake
   logic wake_any;
   // Power-state register
   wec_state_t state_q, state_d;
   // Press length counter
   logic [CNT_W-1:0] press_cnt_q;
   // Press ended while short
   logic press_short;
   // Quiet time after AC return
   logic [CNT_W-1:0] quiet_cnt_q;
   logic quiet_act;
   // Powered-on-since-reset flag (false means just out of G3)
   logic ac_seen_q;
   // Latched cause and display hold
   logic [NSRC-1:0] cause_q;
   logic disp_hold_q;
   // CEC pulses
   wec_cec_t cec_q;
   // Sleep-state decode
   logic in_s3, in_s45, sleeping;

   // Pin synchroniser
   wec_sync #(.W(NSRC)) u_sync
   (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_async(i_wake_pin),
      .o_sync(pin_s)
   );

   // State decode
   assign in_s3 = (state_q == ST_S3);
   assign in_s45 = (state_q == ST_S4) || (state_q == ST_S5);
   assign sleeping = in_s3 || in_s45;
   assign quiet_act = (quiet_cnt_q != '0);
   assign pin_rise = pin_s & ~pin_prev_q;
   // Release of the switch before the long-press limit
   assign press_short = pin_prev_q[SRC_PWRBTN] && !pin_s[SRC_PWRBTN]
                        && (press_cnt_q < CNT_W'(PRESS_LIMIT));

   // Per-source qualification; sources use the rising edge, the switch its release
   assign src_ok[SRC_PWRBTN] = press_short;
   assign src_ok[SRC_RTC] = pin_rise[SRC_RTC] && sleeping;
   assign src_ok[SRC_LAN] = pin_rise[SRC_LAN] && sleeping
                            && !(in_s45 && i_cfg.deep_sleep_en && !ac_seen_q);
   assign src_ok[SRC_USB] = pin_rise[SRC_USB] && !quiet_act
                            && (in_s3 || (in_s45 && i_cfg.usb_s45_en
                                && !i_cfg.deep_sleep_en));
   assign src_ok[SRC_PCIE] = pin_rise[SRC_PCIE] && sleeping;
   assign src_ok[SRC_CIR] = pin_rise[SRC_CIR] && !quiet_act
                            && (in_s3 || (in_s45 && !i_cfg.deep_sleep_en));
   assign src_ok[SRC_BT] = 1'b0;
   // Enable gating common to every source
   assign wake_hit = src_ok & i_cfg.wake_en;
   assign wake_any = sleeping && (wake_hit != '0);

   // Next power state
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_G3:
         begin
            // Policy decides once the clock runs again
            state_d = i_cfg.last_state_on ? ST_S0 : ST_S5;
         end
         ST_S0:
         begin
            // Shutdown outranks sleep requests
            if (i_shutdown_req)
               state_d = ST_S5;
            else if (i_sleep_s4_req)
               state_d = ST_S4;
            else if (i_sleep_s3_req)
               state_d = ST_S3;
         end
         ST_S3, ST_S4, ST_S5:
         begin
            if (wake_any)
               state_d = ST_S0;
         end
         default:
         begin
            // Illegal code: fall back to soft off
            state_d = ST_S5;
         end
      endcase
   end

   // State and edge history
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn)
      begin
         state_q <= ST_G3;
         pin_prev_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         pin_prev_q <= pin_s;
      end
   end

   // Switch press length, saturating so a long press never wraps
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn)
         press_cnt_q <= '0;
      else if (!pin_s[SRC_PWRBTN])
         press_cnt_q <= '0;
      else if (press_cnt_q != '1)
         press_cnt_q <= press_cnt_q + 1'b1;
   end

   // AC return quiet window; reset means power has just come back
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn)
      begin
         quiet_cnt_q <= '0;
         ac_seen_q <= 1'b0;
      end
      else if (state_q == ST_G3)
         quiet_cnt_q <= CNT_W'(AC_QUIET);
      else
      begin
         if (quiet_act)
            quiet_cnt_q <= quiet_cnt_q - 1'b1;
         // Any working period clears the after-G3 condition
         if (state_q == ST_S0)
            ac_seen_q <= 1'b1;
      end
   end

   // Wake cause kept until the next wake; display hold kept until next sleep entry
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn)
      begin
         cause_q <= CAUSE_RST;
         disp_hold_q <= 1'b0;
      end
      else if (wake_any)
      begin
         cause_q <= wake_hit;
         disp_hold_q <= in_s3 && (wake_hit[SRC_RTC] || wake_hit[SRC_LAN]
                        || wake_hit[SRC_PCIE]);
      end
      else if (state_q == ST_S0 && state_d != ST_S0)
         disp_hold_q <= 1'b0;
   end

   // CEC commands on transitions, onboard path only
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn)
         cec_q <= '0;
      else
      begin
         cec_q.tv_standby <= o_cec_onboard_act && state_q == ST_S0
                             && (state_d == ST_S5 || state_d == ST_S3);
         cec_q.tv_on <= o_cec_onboard_act && state_q == ST_S5
                        && state_d == ST_S0;
      end
   end

   // The adaptor wins when present; onboard needs its option too
   assign o_cec_onboard_act = i_cfg.cec_onboard_en && !i_ext_cec_present;
   assign o_cec_ext_act = i_ext_cec_present;

   // Outputs
   assign o_state = state_q;
   assign o_main_pwr_en = (state_q == ST_S0);
   assign o_ctx_keep = in_s3;
   assign o_led = (state_q == ST_S0) ? LED_MAIN
                  : (in_s3 && i_cfg.led_dual) ? LED_ALT : LED_OFF;
   assign o_display_hold = disp_hold_q;
   assign o_wake_cause = cause_q;
   assign o_cec_cmd = cec_q;

   // Wake from sleep reaches S0 the next cycle
   chk_wake_to_s0: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      wake_any |=> state_q == ST_S0)
      else $error("wake did not reach working state");
   // Bluetooth line never causes a wake
   chk_bt_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      sleeping && state_q == $past(state_q) && !wake_hit[SRC_PCIE] && !wake_hit[SRC_RTC]
      && !wake_hit[SRC_LAN] && !wake_hit[SRC_USB] && !wake_hit[SRC_CIR]
      && !wake_hit[SRC_PWRBTN] |=> state_q != ST_S0)
      else $error("wake without a qualified source");
   // USB in S4/S5 with deep standby cannot wake
   chk_usb_deep_gate: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      in_s45 && i_cfg.deep_sleep_en |-> !wake_hit[SRC_USB] && !wake_hit[SRC_CIR])
      else $error("usb or ir wake with deep standby");
   // Quiet window blocks USB and IR
   chk_quiet_block: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      quiet_act |-> !wake_hit[SRC_USB] && !wake_hit[SRC_CIR])
      else $error("usb or ir wake during quiet window");
   // Amber in S3 for dual indicator
   chk_s3_led: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      in_s3 |-> o_led == (i_cfg.led_dual ? LED_ALT : LED_OFF))
      else $error("wrong indicator in suspend");
   // CEC paths exclusive
   chk_cec_excl: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      !(o_cec_onboard_act && o_cec_ext_act))
      else $error("both cec paths active");
   // Standby pulse after S0 leaves to S3/S5
   chk_tv_standby: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      state_q == ST_S0 ##1 (state_q == ST_S5 || state_q == ST_S3)
      |-> o_cec_cmd.tv_standby == o_cec_onboard_act)
      else $error("tv standby missing");
   // TV on after S5 to S0
   chk_tv_on: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      state_q == ST_S5 ##1 state_q == ST_S0 |-> o_cec_cmd.tv_on == o_cec_onboard_act)
      else $error("tv on missing");
   // AC return follows the stored policy; an edge still in reset keeps G3
   chk_ac_policy: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      i_resetn && state_q == ST_G3 |=> state_q == (i_cfg.last_state_on ? ST_S0 : ST_S5))
      else $error("ac return policy not applied");
   // Cause latched on wake
   chk_cause_latch: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      wake_any |=> o_wake_cause == $past(wake_hit))
      else $error("wake cause not latched");

   // Power and display checks
   // Suspend keeps context with main power off
   chk_s3_power_off: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      in_s3 |-> !o_main_pwr_en && o_ctx_keep)
      else $error("main power on in suspend");
   // No display hold after a wake from S4 or S5
   chk_hold_from_s45: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      wake_any && !in_s3 |=> !o_display_hold)
      else $error("display held after deep wake");
   // Timer, network and card wake from S3 keep the display asleep
   chk_hold_from_s3: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      wake_any && in_s3 && (wake_hit[SRC_RTC] || wake_hit[SRC_LAN] || wake_hit[SRC_PCIE])
      |=> o_display_hold)
      else $error("display not held after suspend wake");

   // Source gating checks
   // USB wake from S4/S5 needs its option
   chk_usb_s45_gate: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      in_s45 && !i_cfg.usb_s45_en |-> !wake_hit[SRC_USB])
      else $error("usb wake from deep sleep without option");
   // Network wake before any working period needs deep standby off
   chk_lan_after_g3: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      in_s45 && i_cfg.deep_sleep_en && !ac_seen_q |-> !wake_hit[SRC_LAN])
      else $error("network wake after power loss with deep standby");
   // Quiet window opens on the edge that leaves G3
   chk_quiet_start: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      i_resetn && state_q == ST_G3 |=> quiet_act)
      else $error("quiet window not opened after power return");
   // A long press never counts as a wake
   chk_long_press: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      pin_prev_q[SRC_PWRBTN] && !pin_s[SRC_PWRBTN] && press_cnt_q >= CNT_W'(PRESS_LIMIT)
      |-> !wake_hit[SRC_PWRBTN])
      else $error("long press taken as wake");

   // Wake path checks
   // Network wake frame powers up from suspend
   chk_lan_wake: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      in_s3 && pin_rise[SRC_LAN] && i_cfg.wake_en[SRC_LAN] |=> state_q == ST_S0)
      else $error("network wake ignored");
   // Card wake line wakes from any sleep state
   chk_pcie_wake: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      sleeping && pin_rise[SRC_PCIE] && i_cfg.wake_en[SRC_PCIE] |=> state_q == ST_S0)
      else $error("card wake ignored");
   // Timer alarm wakes from soft off
   chk_rtc_wake: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      state_q == ST_S5 && pin_rise[SRC_RTC] && i_cfg.wake_en[SRC_RTC] |=> state_q == ST_S0)
      else $error("timer wake ignored");
   // USB activity wakes from suspend outside the quiet window
   chk_usb_s3_wake: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      in_s3 && !quiet_act && pin_rise[SRC_USB] && i_cfg.wake_en[SRC_USB] |=> state_q == ST_S0)
      else $error("usb wake ignored");
   // Infrared wakes from S3, and from S4/S5 with deep standby off
   chk_cir_wake: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      (in_s3 || (in_s45 && !i_cfg.deep_sleep_en)) && !quiet_act && pin_rise[SRC_CIR]
      && i_cfg.wake_en[SRC_CIR] |=> state_q == ST_S0)
      else $error("infrared wake ignored");
   // Short press wakes from any sleep state
   chk_short_press: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      sleeping && press_short && i_cfg.wake_en[SRC_PWRBTN] |=> state_q == ST_S0)
      else $error("short press did not wake");

   // CEC command checks
   // No TV command leaves while the onboard path is off
   chk_cmd_onboard: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      !o_cec_onboard_act |=> o_cec_cmd == '0)
      else $error("tv command with onboard path off");
endmodule

// ---- rtl/wec_pkg.sv ----
// Purpose: Shared types and constants for the wake event controller
// Assumes: 20 MHz standby clock
// Notes: Power states, wake source layout, timing counts
package wec_pkg;
   // Clock period in ns
   localparam int CLK_PERIOD_NS = 50;
   // Short press limit (ms)
   localparam int PRESS_LIMIT_MS = 4000;
   // Short press limit in cycles; cycles per ms first so the product fits an int
   localparam int PRESS_LIMIT_CYC = PRESS_LIMIT_MS * (1000000 / CLK_PERIOD_NS);
   // Quiet time for USB/IR after AC return (ms)
   localparam int AC_QUIET_MS = 100;
   // Quiet time in cycles, least time rounded up
   localparam int AC_QUIET_CYC = (AC_QUIET_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Width of the long counters
   localparam int CNT_W = 27;
   // Number of wake sources
   localparam int NSRC = 7;
   // Wake source bit positions
   localparam int SRC_PWRBTN = 0;
   localparam int SRC_RTC = 1;
   localparam int SRC_LAN = 2;
   localparam int SRC_USB = 3;
   localparam int SRC_PCIE = 4;
   localparam int SRC_CIR = 5;
   localparam int SRC_BT = 6;
   // Reset value of the latched wake cause
   localparam logic [NSRC-1:0] CAUSE_RST = 7'h00;

   // System power states
   typedef enum logic [2:0]
   {
      ST_G3 = 3'b000,
      ST_S0 = 3'b001,
      ST_S3 = 3'b011,
      ST_S4 = 3'b100,
      ST_S5 = 3'b101
   } wec_state_t;

   // LED drive
   typedef enum logic [1:0]
   {
      LED_OFF = 2'b00,
      LED_MAIN = 2'b01,
      LED_ALT = 2'b10
   } wec_led_t;

   // Firmware setup options
   typedef struct packed
   {
      logic last_state_on;   // Power state held before AC loss
      logic usb_s45_en;      // USB wake from S4/S5 allowed
      logic deep_sleep_en;   // Deep low-power standby
      logic cec_onboard_en;  // Onboard CEC path enabled
      logic led_dual;        // Dual-colour front indicator fitted
      logic [NSRC-1:0] wake_en; // Per-source wake enables
   } wec_cfg_t;

   // CEC commands toward the TV
   typedef struct packed
   {
      logic tv_on;      // One-cycle pulse: command TV on
      logic tv_standby; // One-cycle pulse: command TV standby
   } wec_cec_t;
endpackage

// ---- rtl/wec_sync.sv ----
// Purpose: Two-stage synchroniser for a vector of pin levels
// Assumes: Inputs asynchronous to i_sys_clk
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module wec_sync
   import wec_pkg::*;
#(
   parameter int W = NSRC
)
(
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   // Metastability catcher, read only by the second stage
   logic [W-1:0] meta_q;
   // Stable sampled value
   logic [W-1:0] sync_q;

   // One flop pair per bit
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_resetn)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule

// ---- bench/wec_src_model.sv ----
// Purpose: Stand-in for the wake sources outside the controller
// Assumes: Bench asks for a pulse of a given length on any set of sources
// Notes: Pins are active-high levels and sit low when no source asserts
`timescale 1ns/100ps
module wec_src_model
   import wec_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic [NSRC-1:0] i_kick,
   input wire logic [7:0] i_len,
   output logic [NSRC-1:0] o_wake_pin
);
   logic [7:0] left_q = 8'h00; // Cycles the pins still stand
   logic [NSRC-1:0] pin_q = '0; // Sources now asserting
   // Idle sources read low so a stale level never looks like a wake
   assign o_wake_pin = (left_q != 8'h00) ? pin_q : '0;
   // Hold the asked sources, the card wake line among them
   // Plain always, since the state starts from declaration values
   always @(posedge i_sys_clk)
   begin
      if (i_kick != '0)
      begin
         pin_q <= i_kick;
         left_q <= i_len;
      end
      else if (left_q != 8'h00)
      begin
         left_q <= left_q - 8'h01;
      end
   end
endmodule

// ---- bench/wec_top_bench.sv ----
// Purpose: Self-checking bench for the wake event controller
// Assumes: Short counts, press limit 20 and quiet window 10 cycles
// Notes: Each step drives one request and waits a bounded time for a change
`timescale 1ns/100ps
module wec_top_bench;
   import wec_pkg::*;
   logic i_sys_clk = 1'b0; // 20 MHz clock
   logic i_resetn = 1'b0; // Active-low reset
   wec_cfg_t cfg; // Setup options
   logic [NSRC-1:0] pin; // Wake pins from the model
   logic [NSRC-1:0] kick = '0; // Pulse request to the model
   logic [7:0] len = 8'h00; // Pulse length
   logic s3 = 1'b0, s4 = 1'b0, shut = 1'b0; // Sleep and shutdown requests
   logic ext = 1'b0; // External adaptor fitted
   wec_state_t o_state;
   logic o_main_pwr_en, o_ctx_keep, o_display_hold, o_cec_onboard_act, o_cec_ext_act;
   wec_led_t o_led;
   logic [NSRC-1:0] o_wake_cause;
   wec_cec_t o_cec_cmd;
   int n_mismatch = 0; // Mismatches seen
   int n_compared = 0; // Comparisons made
   int cyc = 0; // Cycle count for the hang guard

   wec_src_model wec_src_model_i (.i_sys_clk(i_sys_clk), .i_kick(kick), .i_len(len),
      .o_wake_pin(pin));
   wec_top #(.PRESS_LIMIT(20), .AC_QUIET(10)) wec_top_i (.i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn), .i_cfg(cfg), .i_wake_pin(pin), .i_sleep_s3_req(s3),
      .i_sleep_s4_req(s4), .i_shutdown_req(shut), .i_ext_cec_present(ext),
      .o_state(o_state), .o_main_pwr_en(o_main_pwr_en), .o_ctx_keep(o_ctx_keep),
      .o_led(o_led), .o_display_hold(o_display_hold), .o_wake_cause(o_wake_cause),
      .o_cec_onboard_act(o_cec_onboard_act), .o_cec_ext_act(o_cec_ext_act),
      .o_cec_cmd(o_cec_cmd));

   // Clock, half period 25 ns
   always #25 i_sys_clk = ~i_sys_clk;

   // Hang guard, well above the few hundred cycles the steps need
   always @(posedge i_sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch = n_mismatch + 1;
         test_done();
      end
   end

   // Closing report and verdict
   task test_done();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Compare one value with case equality so unknowns fail
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Reset held for two edges; release models power coming back
   task do_reset(input logic on);
      cfg.last_state_on <= on;
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      @(posedge i_sys_clk);
      #1;
   endtask

   // One request: rq is {shutdown, S4, S3}; pins pulse for ln cycles
   task step(input logic [2:0] rq, input logic [NSRC-1:0] pins, input logic [7:0] ln,
      input wec_state_t exp, input logic [1:0] cmd);
      wec_state_t prev;
      logic [1:0] seen_cmd;
      int i;
      prev = o_state;
      seen_cmd = 2'b00;
      @(posedge i_sys_clk);
      {shut, s4, s3} <= rq;
      kick <= pins;
      len <= ln;
      // Any pulse in the window counts, so a stray command shows too
      for (i = 0; i < 40 && o_state === prev; i++)
      begin
         @(posedge i_sys_clk);
         #1;
         kick <= '0;
         seen_cmd = seen_cmd | o_cec_cmd;
      end
      {shut, s4, s3} <= 3'b000;
      chk("state", {5'h00, o_state}, {5'h00, exp});
      chk("tv command", {6'h00, seen_cmd}, {6'h00, cmd});
      repeat (8) @(posedge i_sys_clk);
      #1;
   endtask

   // Main sequence
   initial
   begin
      cfg = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 7'h7f};
      do_reset(1'b1);
      chk("state", {5'h00, o_state}, {5'h00, ST_S0});
      chk("led", {6'h00, o_led}, {6'h00, LED_MAIN});
      chk("cec paths", {6'h00, o_cec_onboard_act, o_cec_ext_act}, 8'h02);
      chk("main power", {7'h00, o_main_pwr_en}, 8'h01);
      step(3'b001, 7'h00, 8'h00, ST_S3, 2'b01);
      chk("context", {7'h00, o_ctx_keep}, 8'h01);
      chk("main power", {7'h00, o_main_pwr_en}, 8'h00);
      chk("led", {6'h00, o_led}, {6'h00, LED_ALT});
      step(3'b000, 7'h04, 8'h04, ST_S0, 2'b00);
      chk("cause", {1'b0, o_wake_cause}, 8'h04);
      chk("display hold", {7'h00, o_display_hold}, 8'h01);
      step(3'b100, 7'h00, 8'h00, ST_S5, 2'b01);
      step(3'b000, 7'h02, 8'h04, ST_S0, 2'b10);
      chk("display hold", {7'h00, o_display_hold}, 8'h00);
      cfg.led_dual <= 1'b0;
      step(3'b001, 7'h00, 8'h00, ST_S3, 2'b01);
      chk("led", {6'h00, o_led}, {6'h00, LED_OFF});
      step(3'b000, 7'h40, 8'h04, ST_S3, 2'b00);
      cfg.wake_en <= 7'h6f;
      step(3'b000, 7'h10, 8'h04, ST_S3, 2'b00);
      cfg.wake_en <= 7'h7f;
      step(3'b000, 7'h10, 8'h04, ST_S0, 2'b00);
      chk("display hold", {7'h00, o_display_hold}, 8'h01);
      step(3'b010, 7'h00, 8'h00, ST_S4, 2'b00);
      cfg.usb_s45_en <= 1'b0;
      step(3'b000, 7'h08, 8'h04, ST_S4, 2'b00);
      cfg.usb_s45_en <= 1'b1;
      cfg.deep_sleep_en <= 1'b1;
      step(3'b000, 7'h08, 8'h04, ST_S4, 2'b00);
      step(3'b000, 7'h20, 8'h04, ST_S4, 2'b00);
      cfg.deep_sleep_en <= 1'b0;
      step(3'b000, 7'h20, 8'h04, ST_S0, 2'b00);
      chk("cause", {1'b0, o_wake_cause}, 8'h20);
      step(3'b001, 7'h00, 8'h00, ST_S3, 2'b01);
      cfg.usb_s45_en <= 1'b0;
      step(3'b000, 7'h08, 8'h04, ST_S0, 2'b00);
      ext <= 1'b1;
      step(3'b000, 7'h00, 8'h00, ST_S0, 2'b00);
      chk("cec paths", {6'h00, o_cec_onboard_act, o_cec_ext_act}, 8'h01);
      step(3'b100, 7'h00, 8'h00, ST_S5, 2'b00);
      ext <= 1'b0;
      step(3'b000, 7'h01, 8'h1e, ST_S5, 2'b00);
      step(3'b000, 7'h01, 8'h06, ST_S0, 2'b10);
      chk("cause", {1'b0, o_wake_cause}, 8'h01);
      cfg.usb_s45_en <= 1'b1;
      do_reset(1'b0);
      chk("state", {5'h00, o_state}, {5'h00, ST_S5});
      step(3'b000, 7'h08, 8'h04, ST_S5, 2'b00);
      cfg.deep_sleep_en <= 1'b1;
      step(3'b000, 7'h04, 8'h04, ST_S5, 2'b00);
      cfg.deep_sleep_en <= 1'b0;
      step(3'b000, 7'h04, 8'h04, ST_S0, 2'b10);
      test_done();
   end
endmodule
